// *** pkg/csp_pkg.sv ***
// Constants, types and helpers for the configuration serial port
// What this block does
// - Transmit and receive paths are independent and run at the same time.
// - Each character is one start bit, eight data bits, no parity, one stop bit.
// - After reset the bit rate is 57.6 kilobaud.
// - Top rate is 57.6 kilobaud; slower rates are also selectable.
// - Software may change the rate setting at run time.
// - Single-ended mode uses request-to-send and clear-to-send for flow control.
// - Single-ended mode drives transmit and request-to-send, receives data and clear-to-send.
// - Switch 10 off selects single-ended; on selects four-wire differential.
// - The mode switch is sampled once after each reset.
// - On a multidrop network this port is a slave answering one master.
// - During firmware download only the selected drive accepts the image.
package csp_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int DATA_BITS = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int DIV_W = 14;
    localparam int SW_W = 10;
    localparam int MODE_SW_BIT = 9;
    localparam int BAUD_57K6 = 57600;
    localparam int BAUD_38K4 = 38400;
    localparam int BAUD_19K2 = 19200;
    localparam int BAUD_9K6 = 9600;
    localparam int BAUD_4K8 = 4800;
    localparam int BAUD_2K4 = 2400;
    localparam int BAUD_1K2 = 1200;
    localparam logic [2:0] RATE_DEFAULT = 3'h0;
    localparam logic [2:0] RATE_LAST = 3'h6;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [DIV_W-1:0] DIV_ZERO = 14'h0000;

    typedef enum logic [1:0] {
        CSP_IDLE = 2'b00,
        CSP_START = 2'b01,
        CSP_DATA = 2'b10,
        CSP_STOP = 2'b11
    } csp_state_e;

    typedef enum logic {
        CSP_SINGLE = 1'b0,
        CSP_DIFF = 1'b1
    } csp_mode_e;

    // Clocks per bit; the fastest entry is the ceiling of the port
    function automatic logic [DIV_W-1:0] csp_bit_div(input logic [2:0] idx);
        int baud;
        case (idx)
            3'h0: baud = BAUD_57K6;
            3'h1: baud = BAUD_38K4;
            3'h2: baud = BAUD_19K2;
            3'h3: baud = BAUD_9K6;
            3'h4: baud = BAUD_4K8;
            3'h5: baud = BAUD_2K4;
            default: baud = BAUD_1K2;
        endcase
        return DIV_W'(CLK_HZ / baud);
    endfunction
endpackage

// *** hdl/csp_uart.sv ***
// Configuration serial port: receive FIFO and the port top level
`timescale 1ns/10ps

module csp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic full_reg;
    logic empty_reg;
    logic push;
    logic pop;

    assign push = in_valid && !full_reg;
    assign pop = out_ready && !empty_reg;
    assign in_ready = !full_reg;
    assign out_valid = !empty_reg;
    assign out_data = mem[rd_ptr_reg];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            full_reg <= 1'b0;
            empty_reg <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
                full_reg <= (count_reg == CNT_FULL - CNT_ONE);
                empty_reg <= 1'b0;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
                full_reg <= 1'b0;
                empty_reg <= (count_reg == CNT_ONE);
            end
        end
    end
endmodule

module csp_uart
    import csp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [SW_W-1:0] front_switch_bank,
    input wire logic [2:0] port_rate_setting,
    input wire logic port_rate_load,
    input wire logic rxd,
    input wire logic cts,
    input wire logic rx_diff,
    input wire logic download_active,
    input wire logic drive_selected,
    input wire logic [DATA_BITS-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [DATA_BITS-1:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic txd,
    output logic rts,
    output logic tx_p,
    output logic tx_n,
    output logic tx_oe,
    output logic diff_mode,
    output logic frame_error,
    output logic rx_overrun
);
    // Divider value loaded by reset; kept as a constant so the reset branch stays constant
    localparam logic [DIV_W-1:0] DIV_DEFAULT = csp_bit_div(RATE_DEFAULT);
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic mode_done_reg;
    csp_mode_e mode_reg;
    logic [2:0] rate_idx_reg;
    logic [DIV_W-1:0] div_reg;
    csp_state_e tx_state_reg;
    logic [DIV_W-1:0] tx_cnt_reg;
    logic [2:0] tx_bit_reg;
    logic [DATA_BITS-1:0] tx_shift_reg;
    logic [DATA_BITS-1:0] tx_hold_reg;
    logic tx_empty_reg;
    logic txd_reg;
    logic tx_oe_reg;
    logic rts_reg;
    csp_state_e rx_state_reg;
    logic [DIV_W-1:0] rx_cnt_reg;
    logic [2:0] rx_bit_reg;
    logic [DATA_BITS-1:0] rx_shift_reg;
    logic push_reg;
    logic [DATA_BITS-1:0] push_data_reg;
    logic ferr_reg;
    logic ovr_reg;
    logic fifo_in_ready;
    logic rx_line;
    logic tx_go;
    logic tx_tick;
    logic rx_tick;

    assign rst_n = rst_sync_reg[1];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode caught once after each reset release; later switch moves are ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_done_reg <= 1'b0;
            mode_reg <= CSP_SINGLE;
        end else if (!mode_done_reg) begin
            mode_done_reg <= 1'b1;
            mode_reg <= csp_mode_e'(front_switch_bank[MODE_SW_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Rate changes only while both paths are idle; a frame starting in that cycle or the next still times its start bit at the old rate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_idx_reg <= RATE_DEFAULT;
            div_reg <= DIV_DEFAULT;
        end else begin
            if (port_rate_load && port_rate_setting <= RATE_LAST &&
                tx_state_reg == CSP_IDLE && rx_state_reg == CSP_IDLE) begin
                rate_idx_reg <= port_rate_setting;
            end
            div_reg <= csp_bit_div(rate_idx_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit path
    assign tx_tick = (tx_cnt_reg == DIV_ZERO);
    assign tx_go = tx_state_reg == CSP_IDLE && !tx_empty_reg &&
                   (cts || mode_reg == CSP_DIFF);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_empty_reg <= 1'b1;
            tx_hold_reg <= '0;
        end else if (tx_go) begin
            tx_empty_reg <= 1'b1;
        end else if (tx_valid && tx_empty_reg) begin
            tx_empty_reg <= 1'b0;
            tx_hold_reg <= tx_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_reg <= CSP_IDLE;
            tx_cnt_reg <= DIV_ZERO;
            tx_bit_reg <= 3'h0;
            tx_shift_reg <= '0;
            txd_reg <= 1'b1;
        end else begin
            case (tx_state_reg)
                CSP_IDLE: begin
                    txd_reg <= 1'b1;
                    if (tx_go) begin
                        tx_state_reg <= CSP_START;
                        tx_shift_reg <= tx_hold_reg;
                        tx_cnt_reg <= div_reg - 1'b1;
                        txd_reg <= 1'b0;
                    end
                end
                CSP_START: begin
                    if (tx_tick) begin
                        tx_state_reg <= CSP_DATA;
                        tx_cnt_reg <= div_reg - 1'b1;
                        tx_bit_reg <= 3'h0;
                        txd_reg <= tx_shift_reg[0];
                        tx_shift_reg <= {1'b0, tx_shift_reg[DATA_BITS-1:1]};
                    end else begin
                        tx_cnt_reg <= tx_cnt_reg - 1'b1;
                    end
                end
                CSP_DATA: begin
                    if (tx_tick) begin
                        tx_cnt_reg <= div_reg - 1'b1;
                        tx_bit_reg <= tx_bit_reg + 1'b1;
                        if (tx_bit_reg == BIT_LAST) begin
                            tx_state_reg <= CSP_STOP;
                            txd_reg <= 1'b1;
                        end else begin
                            txd_reg <= tx_shift_reg[0];
                            tx_shift_reg <= {1'b0, tx_shift_reg[DATA_BITS-1:1]};
                        end
                    end else begin
                        tx_cnt_reg <= tx_cnt_reg - 1'b1;
                    end
                end
                CSP_STOP: begin
                    if (tx_tick) begin
                        tx_state_reg <= CSP_IDLE;
                    end else begin
                        tx_cnt_reg <= tx_cnt_reg - 1'b1;
                    end
                end
                default: tx_state_reg <= CSP_IDLE;
            endcase
        end
    end

    // A multidrop slave releases the shared pair whenever it is not sending
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_oe_reg <= 1'b0;
        end else begin
            // Drop the enable on the edge that ends the stop bit, not one cycle late
            tx_oe_reg <= mode_reg == CSP_DIFF && (tx_go || (tx_state_reg != CSP_IDLE &&
                         !(tx_state_reg == CSP_STOP && tx_tick)));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive path, sampled mid-bit
    assign rx_line = (mode_reg == CSP_DIFF) ? rx_diff : rxd;
    assign rx_tick = (rx_cnt_reg == DIV_ZERO);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_reg <= CSP_IDLE;
            rx_cnt_reg <= DIV_ZERO;
            rx_bit_reg <= 3'h0;
            rx_shift_reg <= '0;
            push_reg <= 1'b0;
            push_data_reg <= '0;
            ferr_reg <= 1'b0;
        end else begin
            push_reg <= 1'b0;
            ferr_reg <= 1'b0;
            case (rx_state_reg)
                CSP_IDLE: begin
                    if (!rx_line) begin
                        rx_state_reg <= CSP_START;
                        rx_cnt_reg <= {1'b0, div_reg[DIV_W-1:1]};
                    end
                end
                CSP_START: begin
                    if (!rx_tick) begin
                        rx_cnt_reg <= rx_cnt_reg - 1'b1;
                    end else if (rx_line) begin
                        rx_state_reg <= CSP_IDLE; // Glitch, not a start bit
                    end else begin
                        rx_state_reg <= CSP_DATA;
                        rx_cnt_reg <= div_reg - 1'b1;
                        rx_bit_reg <= 3'h0;
                    end
                end
                CSP_DATA: begin
                    if (rx_tick) begin
                        rx_cnt_reg <= div_reg - 1'b1;
                        rx_shift_reg <= {rx_line, rx_shift_reg[DATA_BITS-1:1]};
                        rx_bit_reg <= rx_bit_reg + 1'b1;
                        if (rx_bit_reg == BIT_LAST) begin
                            rx_state_reg <= CSP_STOP;
                        end
                    end else begin
                        rx_cnt_reg <= rx_cnt_reg - 1'b1;
                    end
                end
                CSP_STOP: begin
                    if (rx_tick) begin
                        rx_state_reg <= CSP_IDLE;
                        if (!rx_line) begin
                            ferr_reg <= 1'b1;
                        end else if (!download_active || drive_selected) begin
                            push_reg <= 1'b1;
                            push_data_reg <= rx_shift_reg;
                        end
                    end else begin
                        rx_cnt_reg <= rx_cnt_reg - 1'b1;
                    end
                end
                default: rx_state_reg <= CSP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr_reg <= 1'b0;
            rts_reg <= 1'b0;
        end else begin
            ovr_reg <= push_reg && !fifo_in_ready;
            rts_reg <= mode_reg == CSP_SINGLE && fifo_in_ready;
        end
    end

    // Buffer lets a slow consumer lag; once full, request-to-send stalls the far end in single-ended mode
    csp_fifo #(
        .WIDTH(DATA_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push_reg),
        .in_ready(fifo_in_ready),
        .in_data(push_data_reg),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    assign tx_ready = tx_empty_reg;
    assign txd = txd_reg;
    assign tx_p = txd_reg;
    assign tx_n = !txd_reg;
    assign tx_oe = tx_oe_reg;
    assign rts = rts_reg;
    assign diff_mode = mode_reg;
    assign frame_error = ferr_reg;
    assign rx_overrun = ovr_reg;

    ////////////////////////////////////////////////////////////////////////////
    chk_cts_gate: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(tx_state_reg == CSP_START) |-> $past(cts) || mode_reg == CSP_DIFF)
        else $error("transmit started without clear-to-send");
    chk_start_low: assert property (
        @(posedge clk) disable iff (!rst_n)
        tx_state_reg == CSP_START |-> !txd_reg)
        else $error("start bit not low");
    chk_stop_high: assert property (
        @(posedge clk) disable iff (!rst_n)
        tx_state_reg == CSP_STOP |-> txd_reg)
        else $error("stop bit not high");
    chk_rts_full: assert property (
        @(posedge clk) disable iff (!rst_n)
        !fifo_in_ready |=> !rts_reg)
        else $error("request-to-send high while buffer full");
    chk_mode_frozen: assert property (
        @(posedge clk) disable iff (!rst_n)
        mode_done_reg |=> $stable(mode_reg))
        else $error("mode changed after power-up");
    chk_rate_range: assert property (
        @(posedge clk) disable iff (!rst_n)
        rate_idx_reg <= RATE_LAST)
        else $error("rate index out of range");
    chk_foreign_drop: assert property (
        @(posedge clk) disable iff (!rst_n)
        push_reg |-> $past(!download_active || drive_selected))
        else $error("unselected drive accepted download data");
    chk_oe_slave: assert property (
        @(posedge clk) disable iff (!rst_n)
        tx_oe_reg |-> mode_reg == CSP_DIFF && tx_state_reg != CSP_IDLE)
        else $error("driver enabled while not sending");
endmodule

// *** testbench/csp_host_model.sv ***
// Host-side model: frames bytes onto the receive line, captures frames from the transmit line
`timescale 1ns/10ps
module csp_host_model (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out
);
    int div = 173;
    logic [7:0] got[$];
    logic stop_bad = 1'b0;

    initial begin
        line_out = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The host is the only master on this link and talks to this one drive
    task automatic send(input logic [7:0] b, input logic good_stop);
        @(posedge clk);
        #1 line_out = 1'b0;
        repeat (div) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            #1 line_out = b[i];
            repeat (div) @(posedge clk);
        end
        #1 line_out = good_stop;
        repeat (div) @(posedge clk);
        #1 line_out = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Samples mid-bit, so a wrong bit period shows up as corrupt data
    always begin : capture
        logic [7:0] b;
        @(posedge clk);
        if (line_in === 1'b0) begin
            repeat (div / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (div) @(posedge clk);
                b[i] = line_in;
            end
            repeat (div) @(posedge clk);
            if (line_in !== 1'b1) stop_bad = 1'b1;
            got.push_back(b);
        end
    end
endmodule

// *** testbench/config_serial_port_uart_tb_top.sv ***
// Self-checking bench for the configuration serial port
`timescale 1ns/10ps
module config_serial_port_uart_tb_top;
    import csp_pkg::*;
    logic clk, rst_b, port_rate_load, cts, download_active, drive_selected, tx_valid, rx_ready;
    logic [SW_W-1:0] sw;
    logic [2:0] rate;
    logic [DATA_BITS-1:0] tx_data, rx_data;
    logic ser, tx_ready, rx_valid, txd, rts, tx_p, tx_n, tx_oe, diff_mode, frame_error, rx_overrun;
    int n_errors = 0;
    int cmp_count = 0;
    int fe_cnt = 0;
    int ov_cnt = 0;
    integer seed = 32'hd6c6;
    logic [7:0] q[$];

    csp_uart u_csp_uart (.clk(clk), .rst_b(rst_b), .front_switch_bank(sw),
        .port_rate_setting(rate), .port_rate_load(port_rate_load), .rxd(ser), .cts(cts),
        .rx_diff(ser), .download_active(download_active), .drive_selected(drive_selected),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .txd(txd), .rts(rts), .tx_p(tx_p),
        .tx_n(tx_n), .tx_oe(tx_oe), .diff_mode(diff_mode), .frame_error(frame_error),
        .rx_overrun(rx_overrun));
    csp_host_model u_csp_host_model (.clk(clk), .line_in(txd), .line_out(ser));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // One-cycle pulses are counted here so no test can miss them
    always @(posedge clk) begin
        if (frame_error === 1'b1) fe_cnt++;
        if (rx_overrun === 1'b1) ov_cnt++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic int exp_div(input logic [2:0] idx);
        int baud[7] = '{BAUD_57K6, BAUD_38K4, BAUD_19K2, BAUD_9K6, BAUD_4K8, BAUD_2K4, BAUD_1K2};
        return CLK_HZ / baud[idx];
    endfunction

    task automatic do_reset(input logic diff);
        sw = '0;
        sw[MODE_SW_BIT] = diff;
        rst_b = 1'b0;
        step(5);
        chk("reset_outs", {txd, tx_n, rts, tx_oe, tx_ready, rx_valid}, 6'h22);
        rst_b = 1'b1;
        step(6);
        chk("diff_mode", diff_mode, diff);
        chk("rts_idle", rts, !diff);
    endtask

    task automatic tx_put(input logic [7:0] b);
        int n;
        n = 0;
        tx_data = b;
        tx_valid = 1'b1;
        @(posedge clk);
        while (tx_ready !== 1'b1 && n < 30000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 30000) n_errors++;
        #1 tx_valid = 1'b0;
        step(1);
    endtask

    task automatic rx_get(input logic [7:0] exp);
        int n;
        n = 0;
        while (rx_valid !== 1'b1 && n < 40000) begin
            step(1);
            n++;
        end
        if (n >= 40000) n_errors++;
        chk("rx_data", rx_data, exp);
        rx_ready = 1'b1;
        step(1);
        rx_ready = 1'b0;
        step(1);
    endtask

    task automatic host_got(input logic [7:0] exp);
        int n;
        n = 0;
        while (u_csp_host_model.got.size() == 0 && n < 40000) begin
            step(1);
            n++;
        end
        chk("txd_byte", (n < 40000) ? u_csp_host_model.got.pop_front() : 8'hxx, exp);
    endtask

    // Load waits out any frame still ending, since a busy port ignores it
    task automatic load_rate(input logic [2:0] idx);
        step(1100);
        rate = idx;
        port_rate_load = 1'b1;
        step(1);
        port_rate_load = 1'b0;
        step(3);
    endtask

    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(90000 * 100);
        n_errors++;
        close_out();
    end

    initial begin
        {rst_b, port_rate_load, download_active, drive_selected, tx_valid, rx_ready} = '0;
        {sw, rate, tx_data, cts} = {10'h000, 3'h0, 8'h00, 1'b1};
        do_reset(1'b0);
        q = '{8'h00, 8'hff, 8'($random(seed)), 8'($random(seed))};
        fork
            for (int i = 0; i < 4; i++) tx_put(q[i]);
            for (int i = 0; i < 4; i++) u_csp_host_model.send(q[3-i], 1'b1);
        join
        for (int i = 0; i < 4; i++) begin
            host_got(q[i]);
            rx_get(q[3-i]);
        end
        $display("full duplex test done");
        cts = 1'b0;
        tx_put(8'h5a);
        step(400);
        chk("tx_held", {txd, 8'(u_csp_host_model.got.size())}, 9'h100);
        cts = 1'b1;
        host_got(8'h5a);
        $display("clear to send test done");
        q = {};
        for (int i = 0; i < 9; i++) begin
            q.push_back(8'($random(seed)));
            u_csp_host_model.send(q[i], 1'b1);
            step(5);
            if (i == 7) chk("rts_full", rts, 1'b0);
        end
        chk("overrun", ov_cnt, 1);
        for (int i = 0; i < 8; i++) rx_get(q[i]);
        chk("rts_free", rts, 1'b1);
        u_csp_host_model.send(8'h3c, 1'b0);
        step(5);
        chk("frame_err", {8'(fe_cnt), rx_valid}, 9'h002);
        $display("buffer and framing test done");
        load_rate(3'h3);
        u_csp_host_model.div = exp_div(3'h3);
        fork
            tx_put(8'ha5);
            u_csp_host_model.send(8'h96, 1'b1);
        join
        host_got(8'ha5);
        rx_get(8'h96);
        load_rate(3'h0);
        load_rate(3'h7);
        u_csp_host_model.div = exp_div(3'h0);
        tx_put(8'h81);
        host_got(8'h81);
        $display("rate test done");
        do_reset(1'b1);
        cts = 1'b0;
        sw[MODE_SW_BIT] = 1'b0;
        step(2);
        chk("mode_kept", diff_mode, 1'b1);
        tx_put(8'h6e);
        for (int n = 0; n < 2000 && txd !== 1'b0; n++) step(1);
        chk("diff_drive", {tx_oe, tx_n, tx_p, rts}, 4'hc);
        host_got(8'h6e);
        step(200);
        chk("diff_release", tx_oe, 1'b0);
        download_active = 1'b1;
        u_csp_host_model.send(8'hc3, 1'b1);
        step(20);
        chk("dl_ignored", rx_valid, 1'b0);
        drive_selected = 1'b1;
        u_csp_host_model.send(8'h3c, 1'b1);
        rx_get(8'h3c);
        $display("differential test done");
        close_out();
    end
endmodule
